// [rtl/igp_pkg.sv]
// igp_pkg: constants shared by the inverter gate protection block
// assumes a 25 MHz system clock; times are in nanoseconds
package igp_pkg;
   localparam int CLK_NS = 40;
   // shortest on pulse the device must honour, ns
   localparam int MIN_ON_PULSE_NS = 1300;
   // shortest off pulse the device must honour, ns
   localparam int MIN_OFF_PULSE_NS = 3000;
   // leg blanking the host keeps, ns
   localparam int LEG_BLANKING_NS = 2700;
   // accepted pulses pass when stable this long; must stay below the minimum widths
   localparam int ON_FILT_CYC = MIN_ON_PULSE_NS / CLK_NS / 4;
   localparam int OFF_FILT_CYC = ON_FILT_CYC;
   // fault pulse length, 1.6 ms minimum
   localparam int FAULT_PULSE_LEN_NS = 1600000;
   localparam int FAULT_PULSE_CYC = (FAULT_PULSE_LEN_NS + CLK_NS - 1) / CLK_NS;
   localparam int NPH = 3;
   localparam int SYNC_W = 3;
endpackage : igp_pkg

// [rtl/igp_sync_if.sv]
// igp_sync_if: carries synchronised protection flags between modules
// assumes both ends share sys_clk
`timescale 1ns/100ps
`default_nettype none
interface igp_sync_if;
   logic short_trip;
   logic low_uv;
   logic [2:0] high_uv;
   modport src (output short_trip, output low_uv, output high_uv);
   modport dst (input short_trip, input low_uv, input high_uv);
endinterface : igp_sync_if
`default_nettype wire

// [rtl/igp_sync.sv]
// igp_sync: three-stage synchronisers for the analog comparator flags
// assumes raw flags are asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module igp_sync (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [4:0] raw,
   igp_sync_if.src flags
);
   logic [4:0] s1;
   logic [4:0] s2;
   logic [4:0] s3;
   logic [4:0] held;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s1 <= 5'h00;
         s2 <= 5'h00;
         s3 <= 5'h00;
      end else begin
         s1 <= raw;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // a change counts once stage two and three agree
   genvar g;
   for (g = 0; g < 5; g++) begin : g_agree
      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            held[g] <= 1'b0;
         end else if (s2[g] == s3[g]) begin
            held[g] <= s3[g];
         end
      end
   end
   assign flags.short_trip = held[0];
   assign flags.low_uv = held[1];
   assign flags.high_uv = held[4:2];
endmodule : igp_sync
`default_nettype wire

// [rtl/igp_top.sv]
// igp_top: gate command passing and protection sequencing for a 3-phase bridge
// assumes host pwm commands arrive asynchronously; fault_out_n has an external pull-up
// Functional notes
// - On pulses shorter than 1.3 us may be ignored; the host keeps them at least that long.
// - Off pulses must last 3.0 us (5.0 us at high current); shorter ones may be ignored.
// - Short-circuit detection uses the filtered sense input and acts on low-side switches only.
// - A short circuit forces all three low-side gates off at once whatever the commands.
// - A short-circuit trip asserts the fault output for a configured pulse length.
// - After the fault pulse each low-side switch stays off until its own fresh rising command.
// - Low-side supply undervoltage turns all low-side switches off regardless of command.
// - Low-side undervoltage holds the fault at least the pulse length and while below release.
// - After low-side supply recovers, each low switch waits for its own rising command.
// - High-side supply undervoltage turns off only that phase's high switch, with no fault.
// - After high-side supply recovers, that switch waits for its next rising command.
// - Commands are active high and an undriven input reads as off.
// - The fault output is open-drain active low; the host supplies the pull-up.
// - Only short circuit and low-side undervoltage assert the fault output.
`timescale 1ns/100ps
`default_nettype none
module igp_top #(
   parameter int FAULT_PULSE_LEN = igp_pkg::FAULT_PULSE_CYC,
   parameter int FILT_CYC = igp_pkg::ON_FILT_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic phase_a_high_cmd,
   input wire logic phase_b_high_cmd,
   input wire logic phase_c_high_cmd,
   input wire logic phase_a_low_cmd,
   input wire logic phase_b_low_cmd,
   input wire logic phase_c_low_cmd,
   input wire logic short_circuit_trip,
   input wire logic low_supply_uv,
   input wire logic [2:0] high_supply_uv,
   output logic [2:0] high_gate,
   output logic [2:0] low_gate,
   input wire logic fault_out_n_in,
   output logic fault_out_n_out,
   output logic fault_out_n_oe_n
);
   localparam int NPH = igp_pkg::NPH;
   localparam int CW = $clog2(FAULT_PULSE_LEN + 1);
   localparam int FW = $clog2(FILT_CYC + 1);

   typedef enum logic [1:0] {
      IGP_IDLE = 2'b00,
      IGP_PULSE = 2'b01,
      IGP_HOLD = 2'b10
   } igp_fault_e;

   igp_sync_if sync_bus ();
   // comparator levels are asynchronous, so they enter through the synchroniser
   igp_sync u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .raw({high_supply_uv, low_supply_uv, short_circuit_trip}),
      .flags(sync_bus)
   );

   logic [5:0] raw_cmd;
   logic [5:0] c1;
   logic [5:0] c2;
   logic [5:0] c3;
   logic [5:0] cmd;
   logic [5:0] cmd_d;
   logic [5:0] rise;
   logic [FW-1:0] filt_cnt [6];
   logic [2:0] low_block;
   logic [2:0] high_block;
   logic low_block_req;
   logic short_d;
   logic short_rise;
   igp_fault_e fstate;
   logic [CW-1:0] fcnt;

   // an undriven pin is pulled low and so is simply an off command
   assign raw_cmd = {phase_c_low_cmd, phase_b_low_cmd, phase_a_low_cmd,
                     phase_c_high_cmd, phase_b_high_cmd, phase_a_high_cmd};

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         c1 <= 6'h00;
         c2 <= 6'h00;
         c3 <= 6'h00;
      end else begin
         c1 <= raw_cmd;
         c2 <= c1;
         c3 <= c2;
      end
   end

   // glitch filter: a level must stand FILT_CYC + 1 cycles; far shorter than the
   // 1.3 us / 3.0 us minimums so any legal pulse always passes
   genvar g;
   for (g = 0; g < 6; g++) begin : g_filt
      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            filt_cnt[g] <= '0;
            cmd[g] <= 1'b0;
         end else if (c2[g] != c3[g] || c3[g] == cmd[g]) begin
            filt_cnt[g] <= '0;
         end else if (filt_cnt[g] == FW'(FILT_CYC)) begin
            cmd[g] <= c3[g];
            filt_cnt[g] <= '0;
         end else begin
            filt_cnt[g] <= filt_cnt[g] + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cmd_d <= 6'h00;
      end else begin
         cmd_d <= cmd;
      end
   end
   assign rise = cmd & ~cmd_d;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         short_d <= 1'b0;
      end else begin
         short_d <= sync_bus.short_trip;
      end
   end
   assign short_rise = sync_bus.short_trip & ~short_d;

   // fault sequencing: short circuit or low-side undervoltage only
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         fstate <= IGP_IDLE;
         fcnt <= '0;
      end else begin
         unique case (fstate)
            IGP_IDLE: begin
               if (short_rise || sync_bus.low_uv) begin
                  fstate <= IGP_PULSE;
                  fcnt <= CW'(FAULT_PULSE_LEN - 1);
               end
            end
            IGP_PULSE: begin
               if (fcnt != '0) begin
                  fcnt <= fcnt - 1'b1;
               end else if (sync_bus.low_uv) begin
                  fstate <= IGP_HOLD;
               end else begin
                  fstate <= IGP_IDLE;
               end
            end
            IGP_HOLD: begin
               if (!sync_bus.low_uv) begin
                  fstate <= IGP_IDLE;
               end
            end
            default: fstate <= IGP_IDLE;
         endcase
      end
   end

   // low sides stay blocked while trip or pulse lasts, then until own rising edge
   assign low_block_req = sync_bus.short_trip | sync_bus.low_uv | (fstate != IGP_IDLE);
   for (g = 0; g < NPH; g++) begin : g_low
      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            low_block[g] <= 1'b0;
         end else if (low_block_req) begin
            low_block[g] <= 1'b1;
         end else if (rise[NPH+g]) begin
            low_block[g] <= 1'b0;
         end
      end
   end

   // high side: supply check only, never the short-circuit flag
   for (g = 0; g < NPH; g++) begin : g_high
      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            high_block[g] <= 1'b0;
         end else if (sync_bus.high_uv[g]) begin
            high_block[g] <= 1'b1;
         end else if (rise[g]) begin
            high_block[g] <= 1'b0;
         end
      end
   end

   // a blocked switch comes back only in the cycle its own command rises
   function automatic logic [2:0] igp_allow(input logic [2:0] on, input logic [2:0] blocked,
                                            input logic [2:0] fresh);
      return on & (~blocked | fresh);
   endfunction : igp_allow

   // gates are cut on the clock edge after the block request appears
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         high_gate <= 3'h0;
         low_gate <= 3'h0;
      end else begin
         high_gate <= igp_allow(cmd[2:0], high_block, rise[2:0])
                      & ~sync_bus.high_uv;
         low_gate <= low_block_req ? 3'h0 :
                     igp_allow(cmd[5:3], low_block, rise[5:3]);
      end
   end

   // fault_out_n_in only mirrors the pin for the host; the sequencing never needs it
   // open drain: drive low only, enable active low while sinking
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         fault_out_n_out <= 1'b0;
         fault_out_n_oe_n <= 1'b1;
      end else begin
         fault_out_n_out <= 1'b0;
         fault_out_n_oe_n <= (fstate == IGP_IDLE) && !(short_rise || sync_bus.low_uv);
      end
   end
endmodule : igp_top
`default_nettype wire

// [tb/igp_asserts.sv]
// igp_asserts: protection timing checks on the igp_top ports
// assumes pins held >= 6 cycles so the synchronised flags see them
`timescale 1ns/100ps
`default_nettype none
module igp_asserts #(
   parameter int FAULT_PULSE_LEN = 50
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic phase_a_low_cmd,
   input wire logic short_circuit_trip,
   input wire logic low_supply_uv,
   input wire logic [2:0] high_supply_uv,
   input wire logic [2:0] high_gate,
   input wire logic [2:0] low_gate,
   input wire logic fault_out_n_out,
   input wire logic fault_out_n_oe_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   int low_cnt;
   logic uv_seen;
   always_ff @(posedge sys_clk) begin
      if (!reset_n || fault_out_n_oe_n) low_cnt <= 0;
      else low_cnt <= low_cnt + 1;
   end
   // an undervoltage pulse may legally run past the nominal length
   always_ff @(posedge sys_clk) begin
      if (!reset_n || (fault_out_n_oe_n && !low_supply_uv)) uv_seen <= 1'b0;
      else if (low_supply_uv) uv_seen <= 1'b1;
   end
   sequence short_edge;
      $rose(short_circuit_trip);
   endsequence
   sequence pulse_end;
      $rose(fault_out_n_oe_n);
   endsequence
   short_lowoff_a: assert property (short_edge |-> ##[1:6] low_gate == 3'h0)
      else $error("low gates still on after short circuit");
   short_fault_a: assert property (short_edge |-> ##[1:6] !fault_out_n_oe_n)
      else $error("no fault after short circuit");
   pulse_min_a: assert property (pulse_end |-> low_cnt >= FAULT_PULSE_LEN)
      else $error("fault pulse too short");
   pulse_max_a: assert property (pulse_end and !uv_seen |-> low_cnt <= FAULT_PULSE_LEN + 1)
      else $error("fault pulse too long");
   fault_src_a: assert property ($fell(fault_out_n_oe_n) |->
      $past(short_circuit_trip, 4) || $past(low_supply_uv, 4))
      else $error("fault without a cause");
   fault_sink_a: assert property (fault_out_n_out == 1'b0)
      else $error("fault pin driven high");
   fault_gate_a: assert property (!fault_out_n_oe_n |-> low_gate == 3'h0)
      else $error("low gate on during fault");
   uv_hold_a: assert property (low_supply_uv [*6] |->
      !fault_out_n_oe_n && low_gate == 3'h0)
      else $error("undervoltage not held");
   hi_uv_a: assert property ($stable(high_supply_uv) [*6] |->
      (high_gate & high_supply_uv) == 3'h0)
      else $error("high gate on in undervoltage");
   rearm_cmd_a: assert property ($rose(low_gate[0]) |-> phase_a_low_cmd)
      else $error("low gate rose without command");
endmodule : igp_asserts
bind igp_top igp_asserts #(.FAULT_PULSE_LEN(FAULT_PULSE_LEN)) i_chk (.sys_clk(sys_clk),
   .reset_n(reset_n), .phase_a_low_cmd(phase_a_low_cmd),
   .short_circuit_trip(short_circuit_trip), .low_supply_uv(low_supply_uv),
   .high_supply_uv(high_supply_uv), .high_gate(high_gate), .low_gate(low_gate),
   .fault_out_n_out(fault_out_n_out), .fault_out_n_oe_n(fault_out_n_oe_n));
`default_nettype wire

// [tb/igp_host.sv]
// igp_host: host controller model issuing leg commands and pulling up the fault pin
// assumes 40 ns clock; requested states never turn both switches of a leg on
`timescale 1ns/100ps
`default_nettype none
module igp_host (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [2:0] hreq,
   input wire logic [2:0] lreq,
   output logic [2:0] hcmd,
   output logic [2:0] lcmd,
   input wire logic oe_n,
   input wire logic drv,
   output logic pin
);
   // 75 cycles covers blanking, minimum on and minimum off at once
   localparam int HOLD = 75;
   int cnt [3];
   assign pin = oe_n ? 1'b1 : drv;
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (!reset_n) begin
            hcmd[i] <= 1'b0;
            lcmd[i] <= 1'b0;
            cnt[i] <= 0;
         end else if (cnt[i] < HOLD) begin
            cnt[i] <= cnt[i] + 1;
         end else if ({hcmd[i], lcmd[i]} != {hreq[i], lreq[i]}) begin
            cnt[i] <= 0;
            // never swap sides directly: off first, the other side a hold later
            hcmd[i] <= (hcmd[i] | lcmd[i]) ? 1'b0 : hreq[i];
            lcmd[i] <= (hcmd[i] | lcmd[i]) ? 1'b0 : lreq[i];
         end
      end
   end
endmodule : igp_host
`default_nettype wire

// [tb/testbench.sv]
// testbench: drives igp_top through the host model and checks gates and fault pin
// assumes a shortened fault pulse of PLEN cycles
`timescale 1ns/100ps
`default_nettype none
module testbench;
   localparam int PLEN = 50;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic short_pin = 1'b0;
   logic luv = 1'b0;
   logic [2:0] huv = 3'h0;
   logic [2:0] hreq = 3'h0;
   logic [2:0] lreq = 3'h0;
   logic [2:0] hcmd, lcmd, hg, lg;
   logic f_out, f_oe_n, pin;
   int n_fail = 0;
   int n_tests = 0;
   // high request, low request, expected high gates, expected low gates
   logic [11:0] rows [4] = '{12'h000, 12'hE38, 12'h1C7, 12'hAAA};
   always #20 sys_clk = ~sys_clk;
   igp_host i_host (.sys_clk(sys_clk), .reset_n(reset_n), .hreq(hreq), .lreq(lreq),
      .hcmd(hcmd), .lcmd(lcmd), .oe_n(f_oe_n), .drv(f_out), .pin(pin));
   igp_top #(.FAULT_PULSE_LEN(PLEN)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
      .phase_a_high_cmd(hcmd[0]), .phase_b_high_cmd(hcmd[1]), .phase_c_high_cmd(hcmd[2]),
      .phase_a_low_cmd(lcmd[0]), .phase_b_low_cmd(lcmd[1]), .phase_c_low_cmd(lcmd[2]),
      .short_circuit_trip(short_pin), .low_supply_uv(luv), .high_supply_uv(huv),
      .high_gate(hg), .low_gate(lg), .fault_out_n_in(pin),
      .fault_out_n_out(f_out), .fault_out_n_oe_n(f_oe_n));
   task automatic chk(input string nm, input logic [2:0] got, input logic [2:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wt
   // drop a command, then raise it again to give a fresh rising edge
   task automatic recmd(input logic [5:0] off, input logic [5:0] on);
      @(posedge sys_clk) {hreq, lreq} <= off;
      wt(100);
      @(posedge sys_clk) {hreq, lreq} <= on;
      wt(120);
   endtask : recmd
   task automatic finish_test;
      $display("checks %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      wt(1);
      chk("high gates", hg, 3'h0);
      chk("low gates", lg, 3'h0);
      chk("fault pin", {2'b0, pin}, 3'h1);
      foreach (rows[i]) begin
         @(posedge sys_clk) {hreq, lreq} <= rows[i][11:6];
         wt(250);
         chk("high gates", hg, rows[i][5:3]);
         chk("low gates", lg, rows[i][2:0]);
      end
      @(posedge sys_clk) {hreq, lreq} <= 6'h23;
      wt(250);
      @(posedge sys_clk) short_pin <= 1'b1;
      wt(10);
      chk("low gates", lg, 3'h0);
      chk("high gates", hg, 3'h4);
      chk("fault pin", {2'b0, pin}, 3'h0);
      @(posedge sys_clk) short_pin <= 1'b0;
      wt(PLEN + 10);
      chk("fault pin", {2'b0, pin}, 3'h1);
      chk("low gates", lg, 3'h0);
      recmd(6'h22, 6'h23);
      chk("low gates", lg, 3'h1);
      @(posedge sys_clk) luv <= 1'b1;
      wt(2 * PLEN);
      chk("fault pin", {2'b0, pin}, 3'h0);
      chk("low gates", lg, 3'h0);
      @(posedge sys_clk) luv <= 1'b0;
      wt(20);
      chk("fault pin", {2'b0, pin}, 3'h1);
      chk("low gates", lg, 3'h0);
      recmd(6'h22, 6'h23);
      chk("low gates", lg, 3'h1);
      @(posedge sys_clk) huv <= 3'h4;
      wt(20);
      chk("high gates", hg, 3'h0);
      chk("fault pin", {2'b0, pin}, 3'h1);
      @(posedge sys_clk) huv <= 3'h0;
      wt(20);
      chk("high gates", hg, 3'h0);
      recmd(6'h03, 6'h23);
      chk("high gates", hg, 3'h4);
      // a reset in mid-run clears every block; fresh commands then pass again
      @(posedge sys_clk) reset_n <= 1'b0;
      wt(4);
      chk("high gates", hg, 3'h0);
      chk("low gates", lg, 3'h0);
      chk("fault pin", {2'b0, pin}, 3'h1);
      @(posedge sys_clk) reset_n <= 1'b1;
      wt(120);
      chk("high gates", hg, 3'h4);
      chk("low gates", lg, 3'h3);
      finish_test();
   end
   // the run needs about 2300 cycles; allow well over three times that
   initial begin
      #400000;
      n_fail++;
      finish_test();
   end
endmodule : testbench
`default_nettype wire
